// ==== testbench/gmd_decoder_sva.sv ====
// Checker for the decoder's word stream and decode outputs
`timescale 1ns/1ps
module gmd_decoder_sva (
    // Clock, reset and fetch stream
    input wire logic               pclk, presetn, word_valid, word_ready,
    input wire logic [15:0]        word_data,
    // Decode results and extensions
    input wire logic               dec_valid, dec_cross, dec_v_clear, dec_illegal, ext_valid,
    input wire gmd_pkg::gmd_kind_t dec_kind,
    input wire logic [3:0]         dec_flag_upd,
    input wire logic [2:0]         dec_words, ext_index,
    input wire logic [5:0]         dec_min_cycles
);
    import gmd_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] op_r;  // Last word on the stream
    logic [2:0]  rem_r; // Extension words still owed
    // Owed-word count lets order be judged without knowing the encodings
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            op_r  <= 16'h0000;
            rem_r <= 3'h0;
        end
        else
        begin
            op_r <= word_data;
            if (dec_valid)
                rem_r <= dec_words - 3'h1;
            else if (ext_valid)
                rem_r <= rem_r - 3'h1;
        end
    a_take_answered: assert property (
        word_valid && word_ready |=> dec_valid || ext_valid) else $error("word not answered");
    a_ext_counted: assert property (
        ext_valid |-> rem_r != 3'h0 && ext_index == dec_words - rem_r) else $error("bad ext index");
    a_opcode_spaced: assert property (
        dec_valid |-> rem_r == 3'h0) else $error("opcode before extensions done");
    a_add_form: assert property (dec_valid && op_r[15:9] == 7'h70 |->
        dec_kind == GMD_XY_ADD && dec_words == 3'h1 && dec_min_cycles == 6'h01
        && dec_flag_upd == 4'hF) else $error("xy add decode wrong");
    a_convert_form: assert property (dec_valid && op_r[15:9] == 7'h74 |->
        dec_kind == GMD_XY_TO_LINEAR_CONVERT && dec_min_cycles == 6'h03
        && dec_flag_upd == 4'h0) else $error("convert decode wrong");
    a_pixel_read: assert property (dec_valid && op_r[15:12] == 4'hF && op_r[10:9] == 2'b01 |->
        dec_min_cycles == (op_r[11] ? 6'h04 : 6'h06)) else $error("pixel read cycles wrong");
    a_reg_move: assert property (dec_valid && op_r[15:10] == 6'h13 |->
        dec_kind == GMD_REG_MOVE && dec_cross == op_r[9] && dec_flag_upd == 4'hA
        && dec_v_clear) else $error("register move decode wrong");
    a_illegal_single: assert property (
        dec_valid && dec_illegal |-> dec_words == 3'h1 && dec_kind == GMD_ILLEGAL)
        else $error("illegal opcode not one word");
endmodule : gmd_decoder_sva

bind gmd_decoder gmd_decoder_sva chk_u (.pclk, .presetn, .word_valid, .word_ready, .word_data,
    .dec_valid, .dec_cross, .dec_v_clear, .dec_illegal, .ext_valid, .dec_kind, .dec_flag_upd,
    .dec_words, .ext_index, .dec_min_cycles);

// ==== testbench/gmd_fetch_model.sv ====
// Fetch-side model that offers queued words to the decoder
`timescale 1ns/1ps
module gmd_fetch_model (
    // Clock, reset and pacing
    input  wire logic   pclk, presetn, stall,
    // Word stream
    output logic        word_valid,
    output logic [15:0] word_data,
    input  wire logic   word_ready
);
    logic [15:0] q[$]; // Words waiting, filled by the bench
    // Hold a word until taken; idle data toggles so a stale word never looks valid
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            word_valid <= 1'b0;
            word_data  <= 16'h0000;
        end
        else if (!word_valid || word_ready)
        begin
            word_valid <= q.size() != 0 && !stall;
            word_data  <= (q.size() != 0 && !stall) ? q.pop_front() : ~word_data;
        end
endmodule : gmd_fetch_model

// ==== testbench/tb.sv ====
// Self-checking bench for the graphics and move opcode decoder
`timescale 1ns/1ps
module tb;
    import gmd_pkg::*;
    // Row: opcode, kind, words, cycles (0 = variable), flags, random field bits
    typedef struct {logic [15:0] op; gmd_kind_t k; logic [2:0] w; logic [5:0] c;
                    logic [3:0] u; logic [9:0] m;} gmd_tv_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, word_valid, word_ready, stall = 1'b0, slow = 1'b0;
    logic        dec_valid, dec_rfile, dec_field_sel, dec_cross, dec_draw_opt, ext_valid;
    logic        dec_variable, dec_v_clear, dec_illegal;
    logic [15:0] word_data, ext_data, lo, mo, rs = 16'h9B4B; // Random state starts at 39755
    logic [3:0]  dec_mode, dec_src, dec_dst, dec_flag_upd;
    logic [4:0]  dec_const;
    logic [2:0]  dec_words, ext_index, xk;
    logic [5:0]  dec_min_cycles;
    gmd_kind_t   dec_kind;
    gmd_tv_t     tv[16], e;     // Opcode table and row under check
    int          xi[$];         // Rows awaiting decode
    logic [15:0] xo[$], xe[$];  // Opcodes and extension words awaiting output
    int          n_fail = 0, checks = 0, cyc = 0, i;

    gmd_decoder dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .word_valid, .word_data, .word_ready, .dec_valid, .dec_kind,
        .dec_mode, .dec_src, .dec_dst, .dec_rfile, .dec_field_sel, .dec_const, .dec_cross,
        .dec_draw_opt, .dec_words, .dec_min_cycles, .dec_variable, .dec_flag_upd,
        .dec_v_clear, .dec_illegal, .ext_valid, .ext_data, .ext_index);
    gmd_fetch_model fm_u (.pclk, .presetn, .stall, .word_valid, .word_data, .word_ready);

    always #12.5 pclk = ~pclk;
    // Fetch hesitates two cycles in three while slow
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        stall <= slow && (cyc % 3 != 0);
    end

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Compare each decode and extension with what was queued
    always @(posedge pclk)
    begin
        if (dec_valid === 1'b1)
        begin
            chk(32'(xi.size() != 0), 32'h1);
            e = tv[xi.size() != 0 ? xi.pop_front() : 0];
            mo = xo.size() != 0 ? xo.pop_front() : 16'h0000;
            xk = 3'h0;
            chk(32'(dec_kind), 32'(e.k));
            chk(32'(dec_words), 32'(e.w));
            chk(32'(dec_flag_upd), 32'(e.u));
            chk({dec_illegal, dec_v_clear}, {e.k == GMD_ILLEGAL, e.u == 4'hA});
            if (e.k != GMD_ILLEGAL)
                chk({dec_variable, dec_min_cycles}, e.c == 6'h0 ? 32'h41 : 32'(e.c));
            if (e.m != 10'h000)
                chk({dec_cross & e.m[9], dec_src, dec_rfile, dec_dst},
                    32'(mo[9:0] & e.m));
            chk({dec_field_sel, dec_const, dec_draw_opt}, {mo[9], mo[9:5], mo[7]});
            if (e.k == GMD_SINGLE_PIXEL_TRANSFER)
                chk(dec_mode, mo[11:9]);
        end
        if (ext_valid === 1'b1)
        begin
            xk = xk + 3'h1;
            chk(32'(ext_index), 32'(xk));
            chk(32'(ext_data), xe.size() != 0 ? xe.pop_front() : ~ext_data);
        end
    end

    // One APB transfer; read data and error taken at the completing edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
            tmo();
        @(posedge pclk);
    endtask : apb

    // Queue an opcode with random fields, then its extension words
    task send(input int r);
        int k;
        rs = nx(rs);
        lo = tv[r].op | {6'h00, rs[9:0] & tv[r].m};
        xi.push_back(r);
        xo.push_back(lo);
        fm_u.q.push_back(lo);
        for (k = 1; k < tv[r].w; k++)
        begin
            rs = nx(rs);
            xe.push_back(rs);
            fm_u.q.push_back(rs);
        end
    endtask : send

    task drain;
        int n;
        for (n = 0; xi.size() + xe.size() + fm_u.q.size() != 0; n++)
            if (n > 3000)
                tmo();
            else
                @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask : drain

    task tmo;
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        final_report();
    endtask : tmo

    task final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        tv[0]  = '{16'hE000, GMD_XY_ADD, 3'h1, 6'h01, 4'hF, 10'h1FF};
        tv[1]  = '{16'hE200, GMD_XY_SUBTRACT, 3'h1, 6'h01, 4'hF, 10'h1FF};
        tv[2]  = '{16'hE400, GMD_XY_COMPARE, 3'h1, 6'h03, 4'hF, 10'h1FF};
        tv[3]  = '{16'hE600, GMD_POINT_WINDOW_COMPARE, 3'h1, 6'h01, 4'h1, 10'h1FF};
        tv[4]  = '{16'hE800, GMD_XY_TO_LINEAR_CONVERT, 3'h1, 6'h03, 4'h0, 10'h1FF};
        tv[5]  = '{16'hEC00, GMD_X_HALF_MOVE, 3'h1, 6'h01, 4'h0, 10'h1FF};
        tv[6]  = '{16'hEE00, GMD_Y_HALF_MOVE, 3'h1, 6'h01, 4'h0, 10'h1FF};
        tv[7]  = '{16'h0FE0, GMD_FILL_XY, 3'h1, 6'h00, 4'h1, 10'h000};
        tv[8]  = '{16'h0F80, GMD_PIXEL_BLOCK_TRANSFER, 3'h1, 6'h00, 4'h0, 10'h000};
        tv[9]  = '{16'hFA00, GMD_SINGLE_PIXEL_TRANSFER, 3'h1, 6'h04, 4'h0, 10'h1FF};
        tv[10] = '{16'hF200, GMD_SINGLE_PIXEL_TRANSFER, 3'h1, 6'h06, 4'h0, 10'h1FF};
        tv[11] = '{16'hAC00, GMD_BYTE_MOVE, 3'h2, 6'h00, 4'h0, 10'h000};
        tv[12] = '{16'h0340, GMD_BYTE_MOVE, 3'h5, 6'h00, 4'h0, 10'h000};
        tv[13] = '{16'h4C00, GMD_REG_MOVE, 3'h1, 6'h01, 4'hA, 10'h3FF};
        tv[14] = '{16'hD400, GMD_FIELD_MOVE, 3'h3, 6'h00, 4'h0, 10'h000};
        tv[15] = '{16'h0300, GMD_ILLEGAL, 3'h1, 6'h00, 4'h0, 10'h000};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 12'h000, 32'h0);
        send(11);
        repeat (4) @(posedge pclk);
        chk({31'(xi.size()), word_ready}, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        drain();
        for (i = 0; i < 16; i++)
            send(i);
        drain();
        slow = 1'b1;
        for (i = 0; i < 80; i++)
        begin
            rs = nx(rs);
            send(rs % 16);
        end
        drain();
        slow = 1'b0;
        apb(1'b1, 12'h000, 32'h3);
        send(2);
        drain();
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, {11'h000, 5'(GMD_XY_COMPARE), lo});
        final_report();
    end
endmodule : tb

// ==== verilog/gmd_decoder.sv ====
// Graphics and move instruction opcode decoder with APB status port
//
// Overview of operation
// - Extract register, file, field, constant, cross, draw fields.
// - 1110000 decodes xy_add, one word, status_flags.
// - 1110001 decodes xy_subtract, one cycle, status_flags.
// - 1110010 decodes xy_compare, three cycles, status_flags.
// - 1110011 point_window_compare, one cycle, V only.
// - 1110100 xy_to_linear_convert, three cycles, no flags.
// - 1110110/111 x_half_move, y_half_move, no flags.
// - Fill linear C0, fill XY E0; XY updates V.
// - Block transfer codes 00..A0; XY destination updates V.
// - Pixel transfer mode bits; XY destination updates V.
// - Indirect read four cycles, XY read six.
// - Variable graphics cycles flagged, not fixed count.
// - One-word byte moves; loads update N Z, clear V.
// - Offset byte moves two words, offset-offset three.
// - Absolute byte moves three words, abs-abs five.
// - Register move, M crosses files, N Z, clear V.
// - Field move modes and directions, F selects size.
// - Field moves with displacement, two or three words.
// - Absolute field moves, three or five words.
// - Variable move cycles flagged, depend on field alignment.
`timescale 1ns/1ps
`include "gmd_defs.svh"

module gmd_decoder (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Instruction word stream from fetch
    input  wire logic                word_valid,
    input  wire logic [15:0]         word_data,
    output logic                     word_ready,
    // Decoded opcode toward execution
    output logic                     dec_valid,
    output gmd_pkg::gmd_kind_t       dec_kind,
    output logic      [3:0]          dec_mode,
    output logic      [3:0]          dec_src,
    output logic      [3:0]          dec_dst,
    output logic                     dec_rfile,
    output logic                     dec_field_sel,
    output logic      [4:0]          dec_const,
    output logic                     dec_cross,
    output logic                     dec_draw_opt,
    output logic      [2:0]          dec_words,
    output logic      [5:0]          dec_min_cycles,
    output logic                     dec_variable,
    output logic      [3:0]          dec_flag_upd,
    output logic                     dec_v_clear,
    output logic                     dec_illegal,
    // Extension words toward execution
    output logic                     ext_valid,
    output logic      [15:0]         ext_data,
    output logic      [2:0]          ext_index
);
    import gmd_pkg::*;

    // Software state
    logic             enable_r;     // Decoder accepts words
    logic [15:0]      dec_cnt_r;    // Opcodes decoded
    logic [15:0]      ill_cnt_r;    // Illegal opcodes seen
    logic [15:0]      last_op_r;    // Most recent opcode
    // Sequencing state
    logic [2:0]       ext_left_r;   // Extension words still owed
    logic [2:0]       ext_left_nxt;
    gmd_dec_t         dec_now;      // Decode of incoming word
    logic             take;         // Word accepted this cycle
    logic             is_opcode;    // Accepted word is an opcode
    logic             apb_wr;
    logic             apb_rd;
    logic             clr_cnt;

    // Fill a decode record
    function automatic gmd_dec_t mk(input gmd_kind_t k, input logic [3:0] m,
                                    input logic [2:0] w, input logic [5:0] c,
                                    input logic v, input logic [3:0] u,
                                    input logic vc);
        gmd_dec_t d;
        d.kind    = k;
        d.mode    = m;
        d.words   = w;
        d.cycles  = c;
        d.varcyc  = v;
        d.upd     = u;
        d.vclr    = vc;
        d.src_low = 1'b0;
        return d;
    endfunction : mk

    // Opcode table; unmatched patterns fall to illegal
    function automatic gmd_dec_t decode(input logic [15:0] op);
        gmd_dec_t d;
        logic     ld;
        d  = mk(GMD_ILLEGAL, 4'h0, `GMD_W1, `GMD_CYC_ONE, 1'b0,
                `GMD_FLG_NONE, 1'b0);
        ld = 1'b0;
        // XY arithmetic and half moves
        if (op[15:12] == 4'hE)
        begin
            case (op[11:9])
                3'h0: d = mk(GMD_XY_ADD, 4'h0, `GMD_W1, `GMD_CYC_ONE,
                             1'b0, `GMD_FLG_STATUS_FLAGS, 1'b0);
                3'h1: d = mk(GMD_XY_SUBTRACT, 4'h0, `GMD_W1, `GMD_CYC_ONE,
                             1'b0, `GMD_FLG_STATUS_FLAGS, 1'b0);
                3'h2: d = mk(GMD_XY_COMPARE, 4'h0, `GMD_W1, `GMD_CYC_THREE,
                             1'b0, `GMD_FLG_STATUS_FLAGS, 1'b0);
                3'h3: d = mk(GMD_POINT_WINDOW_COMPARE, 4'h0, `GMD_W1,
                             `GMD_CYC_ONE, 1'b0, `GMD_FLG_V, 1'b0);
                3'h4: d = mk(GMD_XY_TO_LINEAR_CONVERT, 4'h0, `GMD_W1,
                             `GMD_CYC_THREE, 1'b0, `GMD_FLG_NONE, 1'b0);
                3'h6: d = mk(GMD_X_HALF_MOVE, 4'h0, `GMD_W1, `GMD_CYC_ONE,
                             1'b0, `GMD_FLG_NONE, 1'b0);
                3'h7: d = mk(GMD_Y_HALF_MOVE, 4'h0, `GMD_W1, `GMD_CYC_ONE,
                             1'b0, `GMD_FLG_NONE, 1'b0);
                default: ;
            endcase
        end
        // Single pixel transfers and draw; mode is op[11:9]
        else if (op[15:12] == 4'hF)
        begin
            case (op[11:9])
                3'h3: d = mk(GMD_DRAW_AND_ADVANCE, 4'h0, `GMD_W1,
                             `GMD_CYC_ONE, 1'b1, `GMD_FLG_V, 1'b0);
                3'h5: d = mk(GMD_SINGLE_PIXEL_TRANSFER, {1'b0, op[11:9]},
                             `GMD_W1, `GMD_CYC_FOUR, 1'b0,
                             `GMD_FLG_NONE, 1'b0);
                3'h1: d = mk(GMD_SINGLE_PIXEL_TRANSFER, {1'b0, op[11:9]},
                             `GMD_W1, `GMD_CYC_SIX, 1'b0,
                             `GMD_FLG_NONE, 1'b0);
                3'h0, 3'h2: d = mk(GMD_SINGLE_PIXEL_TRANSFER,
                             {1'b0, op[11:9]}, `GMD_W1, `GMD_CYC_ONE,
                             1'b1, `GMD_FLG_V, 1'b0);
                3'h4, 3'h6: d = mk(GMD_SINGLE_PIXEL_TRANSFER,
                             {1'b0, op[11:9]}, `GMD_W1, `GMD_CYC_ONE,
                             1'b1, `GMD_FLG_NONE, 1'b0);
                default: ;
            endcase
        end
        // Fills and block transfers share one upper byte
        else if (op[15:8] == 8'h0F && op[4:0] == 5'h00)
        begin
            case (op[7:5])
                3'h6: d = mk(GMD_FILL_LINEAR, 4'h0, `GMD_W1, `GMD_CYC_ONE,
                             1'b1, `GMD_FLG_NONE, 1'b0);
                3'h7: d = mk(GMD_FILL_XY, 4'h0, `GMD_W1, `GMD_CYC_ONE,
                             1'b1, `GMD_FLG_V, 1'b0);
                // Odd codes carry an XY destination
                default: d = mk(GMD_PIXEL_BLOCK_TRANSFER, {1'b0, op[7:5]},
                             `GMD_W1, `GMD_CYC_ONE, 1'b1,
                             op[5] ? `GMD_FLG_V : `GMD_FLG_NONE, 1'b0);
            endcase
        end
        // Line draw, draw option in bit 7
        else if (op[15:8] == 8'hDF && op[6:0] == 7'h1A)
            d = mk(GMD_LINE_DRAW, 4'h0, `GMD_W1, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_V, 1'b0);
        // Register to register move
        else if (op[15:10] == 6'h13)
            d = mk(GMD_REG_MOVE, 4'h0, `GMD_W1, `GMD_CYC_ONE, 1'b0,
                   `GMD_FLG_NZ, 1'b1);
        // Byte moves, indirect and offset forms; op[9] = load
        else if (op[11:10] == 2'h3 && (op[15:12] == 4'h8 || op[15:12] == 4'hA))
        begin
            ld = op[9];
            d  = mk(GMD_BYTE_MOVE, {2'h0, op[13], op[9]},
                    op[13] ? `GMD_W2 : `GMD_W1, `GMD_CYC_ONE, 1'b1,
                    ld ? `GMD_FLG_NZ : `GMD_FLG_NONE, ld);
        end
        else if (op[15:9] == 7'h4E)
            d = mk(GMD_BYTE_MOVE, 4'h4, `GMD_W1, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
        else if (op[15:9] == 7'h5E)
            d = mk(GMD_BYTE_MOVE, 4'h5, `GMD_W3, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
        // Absolute byte moves
        else if (op[15:5] == 11'h02F)
        begin
            d = mk(GMD_BYTE_MOVE, 4'h6, `GMD_W3, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
            d.src_low = 1'b1;
        end
        else if (op[15:5] == 11'h03F)
            d = mk(GMD_BYTE_MOVE, 4'h7, `GMD_W3, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NZ, 1'b1);
        else if (op == 16'h0340)
            d = mk(GMD_BYTE_MOVE, 4'h8, `GMD_W5, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
        // One-word field moves: 8 plain, 9 post-inc, A pre-dec
        else if ((op[15:12] == 4'h8 || op[15:12] == 4'h9 || op[15:12] == 4'hA)
                 && op[11:10] != 2'h3)
        begin
            ld = (op[11:10] == 2'h1);
            d  = mk(GMD_FIELD_MOVE, {op[13:12], op[11:10]}, `GMD_W1,
                    `GMD_CYC_ONE, 1'b1, ld ? `GMD_FLG_NZ : `GMD_FLG_NONE,
                    ld);
        end
        // Field moves with displacement
        else if (op[15:12] == 4'hB && op[11:10] != 2'h3)
        begin
            ld = (op[11:10] == 2'h1);
            d  = mk(GMD_FIELD_MOVE, {2'h3, op[11:10]},
                    op[11] ? `GMD_W3 : `GMD_W2, `GMD_CYC_ONE, 1'b1,
                    ld ? `GMD_FLG_NZ : `GMD_FLG_NONE, ld);
        end
        else if (op[15:10] == 6'h34)
            d = mk(GMD_FIELD_MOVE, 4'hC, `GMD_W2, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
        // Absolute field moves
        else if (op[15:10] == 6'h01 && op[8] && op[7:5] == 3'h4)
        begin
            d = mk(GMD_FIELD_MOVE, 4'hD, `GMD_W3, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
            d.src_low = 1'b1;
        end
        else if (op[15:10] == 6'h01 && op[8] && op[7:5] == 3'h5)
            d = mk(GMD_FIELD_MOVE, 4'hE, `GMD_W3, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NZ, 1'b1);
        else if (op[15:10] == 6'h01 && op[8] && op[7:0] == 8'hC0)
            d = mk(GMD_FIELD_MOVE, 4'hF, `GMD_W5, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
        else if (op[15:10] == 6'h35 && !op[8] && op[7:5] == 3'h0)
            d = mk(GMD_FIELD_MOVE, 4'hB, `GMD_W3, `GMD_CYC_ONE, 1'b1,
                   `GMD_FLG_NONE, 1'b0);
        return d;
    endfunction : decode

    // Stream handshake; stall when software disables the decoder
    assign word_ready = enable_r;
    assign take       = word_valid && enable_r;
    assign is_opcode  = (ext_left_r == 3'h0);
    assign dec_now    = decode(word_data);

    // Extension word countdown
    always_comb
    begin
        ext_left_nxt = ext_left_r;
        if (take)
        begin
            if (is_opcode)
                ext_left_nxt = dec_now.words - `GMD_W1;
            else
                ext_left_nxt = ext_left_r - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_left_r <= 3'h0;
        else
            ext_left_r <= ext_left_nxt;
    end

    // Decoded outputs, one pulse per opcode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dec_valid      <= 1'b0;
            dec_kind       <= GMD_ILLEGAL;
            dec_mode       <= 4'h0;
            dec_src        <= 4'h0;
            dec_dst        <= 4'h0;
            dec_rfile      <= 1'b0;
            dec_field_sel  <= 1'b0;
            dec_const      <= 5'h00;
            dec_cross      <= 1'b0;
            dec_draw_opt   <= 1'b0;
            dec_words      <= 3'h0;
            dec_min_cycles <= 6'h00;
            dec_variable   <= 1'b0;
            dec_flag_upd   <= 4'h0;
            dec_v_clear    <= 1'b0;
            dec_illegal    <= 1'b0;
        end
        else
        begin
            dec_valid <= take && is_opcode;
            if (take && is_opcode)
            begin
                dec_kind       <= dec_now.kind;
                dec_mode       <= dec_now.mode;
                // Absolute stores carry the source in the low nibble
                dec_src        <= dec_now.src_low ? word_data[3:0]
                                                  : word_data[8:5];
                dec_dst        <= word_data[3:0];
                dec_rfile      <= word_data[4];
                dec_field_sel  <= word_data[9];
                dec_const      <= word_data[9:5];
                dec_cross      <= word_data[9];
                dec_draw_opt   <= word_data[7];
                dec_words      <= dec_now.words;
                dec_min_cycles <= dec_now.cycles;
                dec_variable   <= dec_now.varcyc;
                dec_flag_upd   <= dec_now.upd;
                dec_v_clear    <= dec_now.vclr;
                dec_illegal    <= (dec_now.kind == GMD_ILLEGAL);
            end
        end
    end

    // Extension words pass through with their position
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_valid <= 1'b0;
            ext_data  <= 16'h0000;
            ext_index <= 3'h0;
        end
        else
        begin
            ext_valid <= take && !is_opcode;
            if (take && is_opcode)
                ext_index <= 3'h0;
            else if (take)
            begin
                ext_data  <= word_data;
                ext_index <= ext_index + 3'h1;
            end
        end
    end

    // APB decode; zero wait states
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !pwrite;
    assign pready  = 1'b1;
    assign clr_cnt = apb_wr && paddr == `GMD_OFS_CTRL && pwdata[`GMD_CTRL_CLR];

    // Unmapped address answers with an error
    always_comb
    begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `GMD_OFS_CTRL: prdata = {31'h0, enable_r};
            `GMD_OFS_STAT: prdata = {ill_cnt_r, dec_cnt_r};
            `GMD_OFS_LAST: prdata = {11'h000, dec_kind, last_op_r};
            default:       pslverr = psel && penable;
        endcase
        if (!apb_rd)
            prdata = 32'h0000_0000;
    end

    // Enable bit; clear bit is self-clearing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable_r <= `GMD_CTRL_RST;
        else if (apb_wr && paddr == `GMD_OFS_CTRL)
            enable_r <= pwdata[`GMD_CTRL_EN];
    end

    // Counters; a decode in the clearing cycle still counts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dec_cnt_r <= 16'h0000;
            ill_cnt_r <= 16'h0000;
            last_op_r <= 16'h0000;
        end
        else
        begin
            if (take && is_opcode)
                last_op_r <= word_data;
            if (take && is_opcode)
                dec_cnt_r <= clr_cnt ? 16'h0001 : dec_cnt_r + 16'h0001;
            else if (clr_cnt)
                dec_cnt_r <= 16'h0000;
            if (take && is_opcode && dec_now.kind == GMD_ILLEGAL)
                ill_cnt_r <= clr_cnt ? 16'h0001 : ill_cnt_r + 16'h0001;
            else if (clr_cnt)
                ill_cnt_r <= 16'h0000;
        end
    end
endmodule : gmd_decoder

// ==== verilog/gmd_defs.svh ====
// Constants for the graphics and move opcode decoder
`ifndef GMD_DEFS_SVH
`define GMD_DEFS_SVH
// Register byte offsets
`define GMD_OFS_CTRL   12'h000
`define GMD_OFS_STAT   12'h004
`define GMD_OFS_LAST   12'h008
// Control field positions and reset
`define GMD_CTRL_EN    0
`define GMD_CTRL_CLR   1
`define GMD_CTRL_RST   1'b1
// Minimum cycle counts
`define GMD_CYC_ONE    6'h01
`define GMD_CYC_THREE  6'h03
`define GMD_CYC_FOUR   6'h04
`define GMD_CYC_SIX    6'h06
// Instruction lengths in words
`define GMD_W1         3'h1
`define GMD_W2         3'h2
`define GMD_W3         3'h3
`define GMD_W5         3'h5
// Flag update masks, bits N C Z V from high to low
`define GMD_FLG_NONE   4'h0
`define GMD_FLG_STATUS_FLAGS   4'hF
`define GMD_FLG_V      4'h1
`define GMD_FLG_NZ     4'hA
`endif

// ==== verilog/gmd_pkg.sv ====
// Types shared by the graphics and move opcode decoder
package gmd_pkg;
    // Instruction kinds recognised by the decoder
    typedef enum logic [4:0] {
        GMD_ILLEGAL,
        GMD_XY_ADD,
        GMD_XY_SUBTRACT,
        GMD_XY_COMPARE,
        GMD_POINT_WINDOW_COMPARE,
        GMD_XY_TO_LINEAR_CONVERT,
        GMD_X_HALF_MOVE,
        GMD_Y_HALF_MOVE,
        GMD_DRAW_AND_ADVANCE,
        GMD_FILL_LINEAR,
        GMD_FILL_XY,
        GMD_LINE_DRAW,
        GMD_PIXEL_BLOCK_TRANSFER,
        GMD_SINGLE_PIXEL_TRANSFER,
        GMD_BYTE_MOVE,
        GMD_REG_MOVE,
        GMD_FIELD_MOVE
    } gmd_kind_t;

    // Result of decoding one opcode word
    typedef struct packed {
        gmd_kind_t   kind;
        logic [3:0]  mode;
        logic [2:0]  words;
        logic [5:0]  cycles;
        logic        varcyc;
        logic [3:0]  upd;
        logic        vclr;
        logic        src_low;
    } gmd_dec_t;
endpackage : gmd_pkg
